/* hw/adio_defines.vh */
// Constants for the auxiliary digital I/O, sync and trigger block
`ifndef ADIO_DEFINES_VH
`define ADIO_DEFINES_VH
// ****************************************************************
// Output source selection codes
// ****************************************************************
`define ADIO_SRC_LOW 3'h0
`define ADIO_SRC_HIGH 3'h1
`define ADIO_SRC_OUTON 3'h2
`define ADIO_SRC_PHASEA 3'h3
`define ADIO_SRC_FAULT 3'h4
`define ADIO_SRC_TRANS 3'h5
`define ADIO_SRC_PROG 3'h6
`define ADIO_SRC_REMOTE 3'h7
// ****************************************************************
// Reset values
// ****************************************************************
`define ADIO_OUT1_RST 3'h2
`define ADIO_OUT2_RST 3'h3
// ****************************************************************
// Timing
// ****************************************************************
`define ADIO_CLK_NS 10
`define ADIO_PULSE_NS 1000
`define ADIO_PULSE_CYC ((`ADIO_PULSE_NS + `ADIO_CLK_NS - 1) / `ADIO_CLK_NS)
`define ADIO_LOCK_CYC 16
// Speed multiplier in thousandths, 1.000 to 10.000
`define ADIO_SPEED_MIN 16'h03e8
`define ADIO_SPEED_MAX 16'h2710
`endif

/* hw/adio_pll.v */
// Phase accumulator engine locked to a sync reference edge
`timescale 1ns/100ps
`include "adio_defines.vh"
module adio_pll #(
   parameter AW = 32
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire ref_edge_i,
   input wire track_i,
   input wire [AW-1:0] fset_i,
   input wire [AW-1:0] dev_limit_i,
   input wire [AW-1:0] offset_i,
   input wire [15:0] speed_i,
   output reg [AW-1:0] phase_o,
   output reg locked_o
);
   reg [AW-1:0] acc_q; // Raw phase accumulator
   reg [AW-1:0] freq_q; // Current frequency word
   reg [4:0] good_q; // Consecutive small-error edges
   reg [AW-1:0] err; // Phase error at reference edge
   reg [AW+15:0] adj; // Scaled correction
   reg [AW-1:0] fnext; // Proposed frequency word
   reg [15:0] spd; // Clamped multiplier
   reg [AW-1:0] acc_d; // Next accumulator value, damping kick included
   // ****************************************************************
   // Correction with clamp to setpoint plus or minus range
   // ****************************************************************
   always @* begin
      spd = speed_i;
      if (spd < `ADIO_SPEED_MIN) begin
         spd = `ADIO_SPEED_MIN;
      end else if (spd > `ADIO_SPEED_MAX) begin
         spd = `ADIO_SPEED_MAX;
      end
      err = acc_q; // Phase error relative to zero
      // Signed error scaled by speed; the deep shift keeps the loop slow at 1.000
      adj = {{16{err[AW-1]}}, err} * {{AW{1'b0}}, spd};
      fnext = freq_q - {{4{adj[AW+15]}}, adj[AW+15:20]};
      // Bound frequency even if the reference stays away
      if ($signed(fnext - fset_i) > $signed(dev_limit_i)) begin
         fnext = fset_i + dev_limit_i;
      end else if ($signed(fset_i - fnext) > $signed(dev_limit_i)) begin
         fnext = fset_i - dev_limit_i;
      end
      // A quarter of the error leaves the phase at each reference edge;
      // the frequency term alone would ring forever and never settle
      acc_d = acc_q + freq_q;
      if (track_i && ref_edge_i) begin
         acc_d = acc_d - {{2{err[AW-1]}}, err[AW-1:2]};
      end
   end
   // ****************************************************************
   // Accumulator, frequency and lock tracking
   // ****************************************************************
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         acc_q <= {AW{1'b0}};
         // Start at the setpoint so the range holds from the first cycle
         freq_q <= fset_i;
         good_q <= 5'h00;
         phase_o <= {AW{1'b0}};
         locked_o <= 1'b0;
      end else begin
         acc_q <= acc_d;
         phase_o <= acc_d + offset_i; // Offset applied to phase A
         if (!track_i) begin
            // Free run at setpoint, lock lost
            freq_q <= fset_i;
            good_q <= 5'h00;
            locked_o <= 1'b0;
         end else if (ref_edge_i) begin
            freq_q <= fnext;
            // Small error counts toward lock
            if (err[AW-1:AW-6] == 6'h00 || err[AW-1:AW-6] == 6'h3f) begin
               if (good_q != `ADIO_LOCK_CYC) begin
                  good_q <= good_q + 5'h01;
               end else begin
                  locked_o <= 1'b1;
               end
            end else begin
               good_q <= 5'h00;
               locked_o <= 1'b0;
            end
         end
      end
   end
endmodule // adio_pll

/* hw/adio_top.v */
// Auxiliary digital outputs, strobes, sync engine and trigger logic
//
// Behaviour
// - Two outputs, fixed level or status source
// - Output-on and phase phase_flag_a status mapping
// - Fault source high while fault present
// - Transient source low only when stopped
// - Program and remote source mapping
// - Reset selects output-on and phase phase_flag_a
// - Per-output polarity flip inverts level
// - Actual pin level readable per output
// - Remote enable and inhibit bits held
// - Strobe on output relay change
// - Strobe on program setting change
// - Strobe at transient start
// - Sync input and output enables readable
// - Fixed phase offset to sync reference
// - Frequency clamped to setpoint plus or minus range
// - Source select: 1 TTL, 0 AC line
// - Loop speed multiplier 1.000 to 10.000
// - Lock status bit from loop
// - Trigger accepted only when enabled
// - Skip_zero_cross start or wait for phase
// - Rearm returns to armed after each run, latched at run command
// - Trigger output pulses, else function strobe
`timescale 1ns/100ps
`include "adio_defines.vh"
module adio_top #(
   parameter AW = 32,
   parameter PULSE_CYC = `ADIO_PULSE_CYC
) (
   input wire MCLK_I,
   input wire RST_N_I,
   // Configuration from the command layer
   input wire [2:0] OUT1_SEL_I,
   input wire [2:0] OUT2_SEL_I,
   input wire OUT1_SEL_WR_I,
   input wire OUT2_SEL_WR_I,
   input wire OUT1_FLIP_I,
   input wire OUT2_FLIP_I,
   input wire REM_ENA_I,
   input wire REM_INH_I,
   input wire STB_RELAY_EN_I,
   input wire STB_PROG_EN_I,
   input wire STB_TRANS_EN_I,
   input wire SYNC_IN_EN_I,
   input wire SYNC_OUT_EN_I,
   input wire SYNC_SRC_TTL_I,
   input wire [AW-1:0] SYNC_OFFSET_I,
   input wire [AW-1:0] FREQ_SET_I,
   input wire [AW-1:0] SYNC_RANGE_I,
   input wire [15:0] SYNC_SPEED_I,
   input wire TRIG_IN_EN_I,
   input wire SKIP_ZC_I,
   input wire REARM_I,
   input wire TRIG_OUT_EN_I,
   input wire [AW-1:0] UPD_PHASE_I,
   // Instrument status
   input wire OUTPUT_ON_I,
   input wire PHASE_PHASE_FLAG_A_SINGLE_I,
   input wire FAULT_I,
   input wire TRANS_ACTIVE_I,
   input wire PROG_RUN_I,
   input wire REMOTE_I,
   input wire PROG_CHANGE_I,
   input wire RUN_CMD_I,
   input wire TRANS_DONE_I,
   // Pins
   input wire SYNC_TTL_I,
   input wire AC_LINE_I,
   input wire TRIG_PIN_I,
   output reg DOUT1_O,
   output reg DOUT2_O,
   output reg SYNC_PIN_O,
   output reg TRIG_PIN_O,
   // Readback and control out
   output reg [1:0] DOUT_LEVEL_O,
   output reg REM_ENA_O,
   output reg REM_INH_O,
   output reg SYNC_IN_EN_O,
   output reg SYNC_OUT_EN_O,
   output reg SYNC_LOCK_O,
   output reg [AW-1:0] PHASE_A_O,
   output reg TRANS_START_O
);
   // ****************************************************************
   // Source selection function
   // ****************************************************************
   // Maps a select code to its status level
   function src_level;
      input [2:0] sel;
      input on, phase_flag_a, flt, tr, prg, rem;
      begin
         case (sel)
            `ADIO_SRC_LOW: src_level = 1'b0;
            `ADIO_SRC_HIGH: src_level = 1'b1;
            `ADIO_SRC_OUTON: src_level = on;
            `ADIO_SRC_PHASEA: src_level = phase_flag_a;
            `ADIO_SRC_FAULT: src_level = flt;
            `ADIO_SRC_TRANS: src_level = tr;
            `ADIO_SRC_PROG: src_level = prg;
            `ADIO_SRC_REMOTE: src_level = rem;
            default: src_level = 1'b0;
         endcase
      end
   endfunction
   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   reg [1:0] ttl_s_q; // Sync TTL pin, two stages
   reg [1:0] ac_s_q; // AC line reference, two stages
   reg [1:0] trg_s_q; // Trigger pin, two stages
   reg ref_prev_q; // Previous synced reference for edges
   // Only the second stage of each pair is read by logic
   always @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         ttl_s_q <= 2'h0;
         ac_s_q <= 2'h0;
         trg_s_q <= 2'h0;
         ref_prev_q <= 1'b0;
      end else begin
         ttl_s_q <= {ttl_s_q[0], SYNC_TTL_I};
         ac_s_q <= {ac_s_q[0], AC_LINE_I};
         trg_s_q <= {trg_s_q[0], TRIG_PIN_I};
         ref_prev_q <= SYNC_SRC_TTL_I ? ttl_s_q[1] : ac_s_q[1];
      end
   end
   wire ref_lvl = SYNC_SRC_TTL_I ? ttl_s_q[1] : ac_s_q[1];
   wire ref_edge = ref_lvl & ~ref_prev_q;
   // ****************************************************************
   // Settings and digital outputs
   // ****************************************************************
   reg [2:0] sel1_q; // Output 1 source
   reg [2:0] sel2_q; // Output 2 source
   reg lvl1;
   reg lvl2;
   always @* begin
      lvl1 = src_level(sel1_q, OUTPUT_ON_I, PHASE_PHASE_FLAG_A_SINGLE_I, FAULT_I,
                       TRANS_ACTIVE_I, PROG_RUN_I, REMOTE_I) ^ OUT1_FLIP_I;
      lvl2 = src_level(sel2_q, OUTPUT_ON_I, PHASE_PHASE_FLAG_A_SINGLE_I, FAULT_I,
                       TRANS_ACTIVE_I, PROG_RUN_I, REMOTE_I) ^ OUT2_FLIP_I;
   end
   // Select registers written only on strobe so reset defaults hold
   always @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         sel1_q <= `ADIO_OUT1_RST;
         sel2_q <= `ADIO_OUT2_RST;
         DOUT1_O <= 1'b0;
         DOUT2_O <= 1'b0;
         DOUT_LEVEL_O <= 2'h0;
         REM_ENA_O <= 1'b0;
         REM_INH_O <= 1'b0;
         SYNC_IN_EN_O <= 1'b0;
         SYNC_OUT_EN_O <= 1'b0;
      end else begin
         if (OUT1_SEL_WR_I) begin
            sel1_q <= OUT1_SEL_I;
         end
         if (OUT2_SEL_WR_I) begin
            sel2_q <= OUT2_SEL_I;
         end
         DOUT1_O <= lvl1;
         DOUT2_O <= lvl2;
         // Readback mirrors the pin registers exactly
         DOUT_LEVEL_O <= {lvl2, lvl1};
         REM_ENA_O <= REM_ENA_I;
         REM_INH_O <= REM_INH_I;
         SYNC_IN_EN_O <= SYNC_IN_EN_I;
         SYNC_OUT_EN_O <= SYNC_OUT_EN_I;
      end
   end
   // ****************************************************************
   // Sync engine
   // ****************************************************************
   wire [AW-1:0] phase_w;
   wire lock_w;
   adio_pll #(
      .AW(AW)
   ) u_pll (
      .clk_i(MCLK_I),
      .rst_n_i(RST_N_I),
      .ref_edge_i(ref_edge),
      .track_i(SYNC_IN_EN_I),
      .fset_i(FREQ_SET_I),
      .dev_limit_i(SYNC_RANGE_I),
      .offset_i(SYNC_OFFSET_I),
      .speed_i(SYNC_SPEED_I),
      .phase_o(phase_w),
      .locked_o(lock_w)
   );
   reg [AW-1:0] phase_prev_q; // For phase crossing detection
   always @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         PHASE_A_O <= {AW{1'b0}};
         SYNC_LOCK_O <= 1'b0;
         SYNC_PIN_O <= 1'b0;
         phase_prev_q <= {AW{1'b0}};
      end else begin
         PHASE_A_O <= phase_w;
         phase_prev_q <= phase_w;
         SYNC_LOCK_O <= lock_w & SYNC_IN_EN_I;
         // Square wave from the phase MSB, held low when disabled
         SYNC_PIN_O <= SYNC_OUT_EN_I & ~phase_w[AW-1];
      end
   end
   // Phase passes the update point between two samples
   wire upd_cross = (phase_w - UPD_PHASE_I) < (phase_w - phase_prev_q);
   // ****************************************************************
   // Trigger handling
   // ****************************************************************
   localparam ST_IDLE = 2'h0; // Not armed
   localparam ST_ARMED = 2'h1; // Run command given, waiting trigger
   localparam ST_WAIT = 2'h2; // Trigger seen, waiting for phase
   localparam ST_RUN = 2'h3; // Sequence running
   reg [1:0] st_q;
   reg [1:0] st_d;
   reg start_d;
   reg rearm_q; // Rearm latched for this run
   // Level-sensitive trigger, gated by enable
   wire trig_ok = TRIG_IN_EN_I & trg_s_q[1];
   always @* begin
      st_d = st_q;
      start_d = 1'b0;
      case (st_q)
         ST_IDLE: begin
            if (RUN_CMD_I) begin
               st_d = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (trig_ok) begin
               if (SKIP_ZC_I) begin
                  st_d = ST_RUN;
                  start_d = 1'b1;
               end else begin
                  st_d = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (upd_cross) begin
               st_d = ST_RUN;
               start_d = 1'b1;
            end
         end
         ST_RUN: begin
            // Rearm returns to armed; high level retriggers
            if (TRANS_DONE_I) begin
               st_d = rearm_q ? ST_ARMED : ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end
   always @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         st_q <= ST_IDLE;
         rearm_q <= 1'b0;
         TRANS_START_O <= 1'b0;
      end else begin
         st_q <= st_d;
         if (RUN_CMD_I) begin
            rearm_q <= REARM_I;
         end
         TRANS_START_O <= start_d;
      end
   end
   // ****************************************************************
   // Strobe and trigger output pulse
   // ****************************************************************
   localparam CW = 16;
   localparam [CW-1:0] PULSE_LEN = PULSE_CYC[CW-1:0];
   reg relay_prev_q; // Output relay state last cycle
   reg [CW-1:0] pcnt_q; // Remaining pulse cycles
   reg fire;
   always @* begin
      fire = 1'b0;
      if (STB_RELAY_EN_I && (OUTPUT_ON_I != relay_prev_q)) begin
         fire = 1'b1;
      end
      if (STB_PROG_EN_I && PROG_CHANGE_I) begin
         fire = 1'b1;
      end
      if ((STB_TRANS_EN_I || TRIG_OUT_EN_I) && start_d) begin
         fire = 1'b1;
      end
   end
   // One pin shared by trigger out and function strobe
   always @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         relay_prev_q <= OUTPUT_ON_I; // Tracks in reset, so release makes no false strobe
         pcnt_q <= {CW{1'b0}};
         TRIG_PIN_O <= 1'b0;
      end else begin
         relay_prev_q <= OUTPUT_ON_I;
         if (fire) begin
            pcnt_q <= PULSE_LEN; // Retrigger restarts width
            TRIG_PIN_O <= 1'b1;
         end else if (pcnt_q > {{(CW-1){1'b0}}, 1'b1}) begin
            pcnt_q <= pcnt_q - {{(CW-1){1'b0}}, 1'b1};
         end else begin
            pcnt_q <= {CW{1'b0}};
            TRIG_PIN_O <= 1'b0;
         end
      end
   end
endmodule // adio_top

/* sim/adio_chk.sv */
// Concurrent checks on the ports of the aux digital I/O block
`timescale 1ns/100ps
module adio_chk #(
   parameter PULSE_CYC = 4
) (
   input wire MCLK_I,
   input wire RST_N_I,
   input wire DOUT1_O,
   input wire DOUT2_O,
   input wire [1:0] DOUT_LEVEL_O,
   input wire REM_ENA_I,
   input wire REM_INH_I,
   input wire REM_ENA_O,
   input wire REM_INH_O,
   input wire SYNC_IN_EN_I,
   input wire SYNC_OUT_EN_I,
   input wire SYNC_IN_EN_O,
   input wire SYNC_OUT_EN_O,
   input wire SYNC_PIN_O,
   input wire SYNC_LOCK_O,
   input wire STB_RELAY_EN_I,
   input wire STB_PROG_EN_I,
   input wire OUTPUT_ON_I,
   input wire PROG_CHANGE_I,
   input wire TRIG_IN_EN_I,
   input wire TRIG_OUT_EN_I,
   input wire RUN_CMD_I,
   input wire TRANS_START_O,
   input wire TRIG_PIN_O
);
   // ****
   // Strobe width counter
   // ****
   reg [15:0] hi_q; // High cycles of the strobe pin so far
   wire [15:0] hi_d = TRIG_PIN_O ? hi_q + 16'h1 : 16'h0;
   // Restarts at every low cycle, so a fall sees the full width
   always @(posedge MCLK_I) begin
      hi_q <= RST_N_I ? hi_d : 16'h0;
   end
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   // ****
   // Properties
   // ****
   lvl_readback_a: assert property (DOUT_LEVEL_O == {DOUT2_O, DOUT1_O})
      else $error("level readback differs from pins");
   rem_echo_a: assert property (1 |=> {REM_ENA_O, REM_INH_O} == $past({REM_ENA_I, REM_INH_I}))
      else $error("remote bits not echoed");
   sync_echo_a: assert property (1 |=> SYNC_IN_EN_O == $past(SYNC_IN_EN_I)
      && SYNC_OUT_EN_O == $past(SYNC_OUT_EN_I)) else $error("sync enables not echoed");
   sync_pin_off_a: assert property ((!SYNC_OUT_EN_I) [*2] |-> !SYNC_PIN_O)
      else $error("sync pin active while disabled");
   relay_stb_a: assert property (STB_RELAY_EN_I && $changed(OUTPUT_ON_I) |-> ##[1:3] TRIG_PIN_O)
      else $error("no strobe on relay change");
   prog_stb_a: assert property (STB_PROG_EN_I && PROG_CHANGE_I |-> ##[1:2] TRIG_PIN_O)
      else $error("no strobe on program change");
   trig_refused_a: assert property ((!TRIG_IN_EN_I && !RUN_CMD_I) [*4] |-> !TRANS_START_O)
      else $error("start while trigger input disabled");
   start_pin_a: assert property (TRANS_START_O && $past(TRIG_OUT_EN_I) |-> TRIG_PIN_O)
      else $error("no trigger pulse at start");
   pulse_width_a: assert property ($fell(TRIG_PIN_O) |-> hi_q == PULSE_CYC)
      else $error("strobe width wrong");
   cover property (TRANS_START_O);
   cover property ($rose(SYNC_LOCK_O));
   cover property ($fell(TRIG_PIN_O));
endmodule // adio_chk
bind adio_top adio_chk #(.PULSE_CYC(PULSE_CYC)) adio_chk_inst (.*);

/* sim/adio_far_end.sv */
// Far-end equipment model: sync source, AC line and trigger press
`timescale 1ns/100ps
module adio_far_end #(
   parameter int HALF = 32
) (
   input wire logic clk_i,
   input wire logic sync_on_i,
   input wire logic trig_req_i,
   output logic sync_o,
   output logic line_o,
   output wire logic trig_o
);
   int cnt_q = 0; // Cycles into the half period
   logic [2:0] press_q = 3'h0; // Recent press requests
   initial begin
      sync_o = 1'b0;
      line_o = 1'b0;
   end
   // Waveforms change off the design's sampling edge
   always @(negedge clk_i) begin
      cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
      press_q <= {press_q[1:0], trig_req_i};
      if (cnt_q == HALF - 1) begin
         // A silent source stands low instead of keeping its phase
         sync_o <= sync_on_i & ~sync_o;
         line_o <= ~line_o;
      end
   end
   // Level trigger is released after three cycles to avoid repeat starts
   assign trig_o = |press_q;
endmodule // adio_far_end

/* sim/adio_top_tb_top.sv */
// Self-checking bench for the aux digital I/O block
`timescale 1ns/100ps
module adio_top_tb_top;
   localparam int PW = 4; // Short strobe keeps the run brief
   logic MCLK_I = 0, RST_N_I = 0, sync_on = 0, trig_req = 0;
   logic [2:0] OUT1_SEL_I, OUT2_SEL_I;
   logic OUT1_SEL_WR_I, OUT2_SEL_WR_I, OUT1_FLIP_I, OUT2_FLIP_I, REM_ENA_I, REM_INH_I;
   logic STB_RELAY_EN_I, STB_PROG_EN_I, STB_TRANS_EN_I, SYNC_IN_EN_I, SYNC_OUT_EN_I;
   logic SYNC_SRC_TTL_I, TRIG_IN_EN_I, SKIP_ZC_I, REARM_I, TRIG_OUT_EN_I, PROG_CHANGE_I;
   logic OUTPUT_ON_I, PHASE_PHASE_FLAG_A_SINGLE_I, FAULT_I, TRANS_ACTIVE_I, PROG_RUN_I, REMOTE_I;
   logic RUN_CMD_I, TRANS_DONE_I;
   logic [31:0] SYNC_OFFSET_I, FREQ_SET_I, SYNC_RANGE_I, UPD_PHASE_I;
   logic [15:0] SYNC_SPEED_I;
   wire SYNC_TTL_I, AC_LINE_I, TRIG_PIN_I, DOUT1_O, DOUT2_O, SYNC_PIN_O, TRIG_PIN_O;
   wire REM_ENA_O, REM_INH_O, TRANS_START_O, SYNC_IN_EN_O, SYNC_OUT_EN_O, SYNC_LOCK_O;
   wire [1:0] DOUT_LEVEL_O;
   wire [31:0] PHASE_A_O;
   int n_mismatch = 0, total_checks = 0, cyc = 0;
   logic exp_q[$]; // Expected strobe pin level at each transient start
   always #5 MCLK_I = ~MCLK_I;
   adio_top #(.PULSE_CYC(PW)) adio_top_inst (.*);
   adio_far_end #(.HALF(32)) adio_far_end_inst (.clk_i(MCLK_I), .sync_on_i(sync_on),
      .trig_req_i(trig_req), .sync_o(SYNC_TTL_I), .line_o(AC_LINE_I), .trig_o(TRIG_PIN_I));
   // ****
   // Helpers
   // ****
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Fixed levels for codes 0 and 1, else one status bit
   function automatic logic src_val(input logic [2:0] s, input logic [5:0] st);
      return (s < 3'h2) ? s[0] : st[s - 3'h2];
   endfunction
   task automatic pls(ref logic s);
      @(negedge MCLK_I) s = 1'b1;
      @(negedge MCLK_I) s = 1'b0;
   endtask
   // High cycles of the strobe pin over a short window
   task automatic hi_cnt(input int exp);
      int n;
      n = 0;
      // After a pls the pulse rose before the caller returned, so the first look is now
      repeat (10) begin
         if (TRIG_PIN_O !== 1'b0) n++;
         @(negedge MCLK_I);
      end
      chk(n, exp);
   endtask
   // Press the trigger; a start, if due, must have come within n cycles
   task automatic trig(input logic s, input int n);
      if (s) exp_q.push_back(1'b1);
      @(negedge MCLK_I) trig_req <= 1'b1;
      @(negedge MCLK_I) trig_req <= 1'b0;
      repeat (n) @(negedge MCLK_I);
      chk(exp_q.size(), 0);
   endtask
   task automatic do_reset();
      logic [1:0] st;
      RST_N_I = 0;
      repeat (6) @(negedge MCLK_I);
      RST_N_I = 1;
      {st, OUT1_FLIP_I, OUT2_FLIP_I} = {$urandom, 2'h0};
      {PHASE_PHASE_FLAG_A_SINGLE_I, OUTPUT_ON_I} = st;
      repeat (2) @(negedge MCLK_I);
      chk({DOUT2_O, DOUT1_O}, st);
      $display("reset test done");
   endtask
   // Each start takes the oldest note; a start with none noted is refused traffic
   always @(negedge MCLK_I) begin
      if (TRANS_START_O === 1'b1) begin
         if (exp_q.size() == 0) chk(8'h1, 8'h0);
         else chk(TRIG_PIN_O, exp_q.pop_front());
      end
   end
   // Hang guard, well above the expected run length
   always @(posedge MCLK_I) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   // ****
   // Main sequence
   // ****
   initial begin
      logic [5:0] st;
      logic [2:0] s;
      logic [1:0] f, x;
      logic [3:0] e;
      int n;
      logic [31:0] p;
      void'($urandom(32'h40c8fb1b));
      {OUT1_SEL_I, OUT2_SEL_I, OUT1_SEL_WR_I, OUT2_SEL_WR_I, OUT1_FLIP_I, OUT2_FLIP_I,
         REM_ENA_I, REM_INH_I, STB_RELAY_EN_I, STB_PROG_EN_I, STB_TRANS_EN_I, SYNC_IN_EN_I,
         SYNC_OUT_EN_I, TRIG_IN_EN_I, SKIP_ZC_I, REARM_I, TRIG_OUT_EN_I, PROG_CHANGE_I,
         OUTPUT_ON_I, PHASE_PHASE_FLAG_A_SINGLE_I, FAULT_I, TRANS_ACTIVE_I, PROG_RUN_I, REMOTE_I,
         RUN_CMD_I, TRANS_DONE_I} = '0;
      SYNC_SRC_TTL_I = 1'b1; // TTL chosen while it is still silent
      {SYNC_OFFSET_I, UPD_PHASE_I} = {$urandom, $urandom};
      {FREQ_SET_I, SYNC_RANGE_I, SYNC_SPEED_I} = {32'h04000000, 32'h00400000, 16'h03e8};
      do_reset();
      for (int i = 0; i < 16; i++) begin
         {st, f, e} = $urandom;
         s = i[2:0];
         @(negedge MCLK_I) {OUT1_SEL_I, OUT2_SEL_I, OUT1_SEL_WR_I, OUT2_SEL_WR_I} = {s, ~s, 2'h3};
         {OUT2_FLIP_I, OUT1_FLIP_I} = f;
         {REMOTE_I, PROG_RUN_I, TRANS_ACTIVE_I, FAULT_I, PHASE_PHASE_FLAG_A_SINGLE_I, OUTPUT_ON_I} = st;
         {REM_ENA_I, REM_INH_I, SYNC_IN_EN_I, SYNC_OUT_EN_I} = e;
         @(negedge MCLK_I) {OUT1_SEL_WR_I, OUT2_SEL_WR_I} = 2'h0;
         @(negedge MCLK_I) x = {src_val(~s, st) ^ f[1], src_val(s, st) ^ f[0]};
         chk({DOUT2_O, DOUT1_O}, x);
         chk(DOUT_LEVEL_O, x);
         chk({REM_ENA_O, REM_INH_O, SYNC_IN_EN_O, SYNC_OUT_EN_O}, e);
      end
      $display("source test done");
      do_reset();
      {TRIG_OUT_EN_I, STB_PROG_EN_I} = 2'h3;
      pls(PROG_CHANGE_I);
      hi_cnt(PW);
      {STB_PROG_EN_I, STB_RELAY_EN_I, OUTPUT_ON_I} = {2'h1, ~OUTPUT_ON_I};
      hi_cnt(PW);
      {STB_RELAY_EN_I, OUTPUT_ON_I} = {1'b0, ~OUTPUT_ON_I};
      pls(PROG_CHANGE_I);
      hi_cnt(0);
      $display("strobe test done");
      {STB_TRANS_EN_I, TRIG_IN_EN_I, SKIP_ZC_I, REARM_I} = 4'he;
      trig(0, 12);
      pls(RUN_CMD_I);
      TRIG_IN_EN_I = 1'b0;
      trig(0, 12);
      TRIG_IN_EN_I = 1'b1;
      trig(1, 12);
      pls(TRANS_DONE_I);
      trig(0, 12);
      REARM_I = 1'b1;
      pls(RUN_CMD_I);
      repeat (3) begin
         trig(1, 12);
         pls(TRANS_DONE_I);
      end
      {REARM_I, SKIP_ZC_I} = 2'h0;
      pls(RUN_CMD_I);
      trig(1, 90);
      $display("trigger test done");
      {SYNC_IN_EN_I, SYNC_OUT_EN_I} = 2'h3;
      repeat (2000) @(negedge MCLK_I);
      chk(SYNC_LOCK_O, 0);
      // No reference edges yet: a new offset shows two pipeline stages later
      p = PHASE_A_O;
      SYNC_OFFSET_I = SYNC_OFFSET_I + 32'h01000000;
      repeat (2) @(negedge MCLK_I);
      chk(PHASE_A_O - p == FREQ_SET_I * 2 + 32'h01000000, 1);
      sync_on = 1'b1;
      for (int k = 0; k < 6000 && SYNC_LOCK_O !== 1'b1; k++) @(negedge MCLK_I);
      chk(SYNC_LOCK_O, 1);
      n = 0;
      repeat (64) @(negedge MCLK_I) if (SYNC_PIN_O === 1'b1) n++;
      chk(n > 0 && n < 64, 1);
      // Drop lock, silence the TTL source and lock again on the AC line
      {SYNC_IN_EN_I, SYNC_SRC_TTL_I, sync_on} = 3'h0;
      repeat (4) @(negedge MCLK_I);
      chk(SYNC_LOCK_O, 0);
      SYNC_IN_EN_I = 1'b1;
      for (int k = 0; k < 6000 && SYNC_LOCK_O !== 1'b1; k++) @(negedge MCLK_I);
      chk(SYNC_LOCK_O, 1);
      $display("sync test done");
      give_verdict();
   end
endmodule // adio_top_tb_top
